// [inc/gcal_pkg.sv]
// Constants, state encodings and storage map for the calibration storage block
package gcal_pkg;

   // Word indices of system register / nonvolatile words (byte address = 4 * index)
   localparam logic [5:0] IDX_SLOT = 6'h02;
   localparam logic [5:0] IDX_TCAL = 6'h04;
   localparam logic [5:0] IDX_TSEL = 6'h09;
   localparam logic [5:0] IDX_SCQB = 6'h2E;
   localparam logic [5:0] IDX_BLIN = 6'h2F;
   localparam logic [5:0] IDX_BCON = 6'h30;
   localparam logic [5:0] IDX_SLIN = 6'h31;
   localparam logic [5:0] IDX_SCON = 6'h32;
   localparam logic [5:0] IDX_MIDTEMP = 6'h33;
   // Block's own command and status words
   localparam logic [5:0] IDX_PROG = 6'h3C;
   localparam logic [5:0] IDX_STAT = 6'h3D;

   // Storage entry numbers, in boot copy order
   localparam int NUM_ENTRY = 9;
   localparam logic [3:0] ENT_SLOT = 4'h0;
   localparam logic [3:0] ENT_TCAL = 4'h1;
   localparam logic [3:0] ENT_TSEL = 4'h2;
   localparam logic [3:0] ENT_SCQB = 4'h3;
   localparam logic [3:0] ENT_BLIN = 4'h4;
   localparam logic [3:0] ENT_BCON = 4'h5;
   localparam logic [3:0] ENT_SLIN = 4'h6;
   localparam logic [3:0] ENT_SCON = 4'h7;
   localparam logic [3:0] ENT_MIDTEMP = 4'h8;

   // Field positions
   localparam int SLOT_LSB = 8;
   localparam int BYPASS_BIT = 27;
   localparam int TGAIN_LSB = 2;
   localparam int TOFS_LSB = 16;
   localparam int TSEL_BIT = 2;
   localparam int TGAIN_FRAC = 9;
   localparam int TEMP_LSB_PER_DEG = 20;

   // Status word bits
   localparam int STAT_BOOTED = 0;
   localparam int STAT_BUSY = 1;
   localparam int STAT_DIRTY = 2;
   localparam int STAT_REFUSED = 3;
   localparam int STAT_FULL = 4;

   // Factory and limit values
   localparam logic [7:0] SLOT_FACTORY = 8'h01;
   localparam logic [7:0] SLOT_FULL = 8'hFF;
   localparam logic [11:0] TGAIN_FACTORY = 12'h800;
   localparam logic [11:0] TOFS_FACTORY = 12'h000;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [NUM_ENTRY-1:0][31:0] MTP_FACTORY = {
      {6{WORD_ZERO}},
      WORD_ZERO,
      (32'(TOFS_FACTORY) << TOFS_LSB) | (32'(TGAIN_FACTORY) << TGAIN_LSB),
      32'(SLOT_FACTORY) << SLOT_LSB};

   // Nonvolatile program time
   localparam int CLK_PERIOD_NS = 50;
   localparam int PROG_TIME_NS = 500;
   localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] TMR_LAST = 4'(PROG_CYCLES - 1);

   // Control states
   typedef enum logic [1:0] {ST_BOOT, ST_RUN, ST_PROG} gcal_state_t;

endpackage

// [verilog/gcal_mtp_store.sv]
// Multi-time-programmable storage words with a pending-coefficient flag
module gcal_mtp_store import gcal_pkg::*; (
   // Clock and storage power-on state
   input wire logic ref_clk,
   input wire logic mtp_por_n,
   // Program port
   input wire logic wr_en,
   input wire logic [3:0] wr_entry,
   input wire logic [31:0] wr_data,
   input wire logic dirty_set,
   input wire logic dirty_clr,
   // Read port
   input wire logic [3:0] rd_entry,
   output logic [31:0] rd_data,
   output logic dirty
);

   logic [31:0] mem [NUM_ENTRY];
   logic dirty_ff;

   // One word per entry; a program overwrites it, so the old value is gone for good
   for (genvar i = 0; i < NUM_ENTRY; i++) begin : g_word
      always_ff @(posedge ref_clk or negedge mtp_por_n) begin
         if (!mtp_por_n) begin
            mem[i] <= MTP_FACTORY[i];
         end else if (wr_en && wr_entry == 4'(i)) begin
            mem[i] <= wr_data;
         end
      end
   end

   // Set wins over clear: a coefficient program must never look committed
   always_ff @(posedge ref_clk or negedge mtp_por_n) begin
      if (!mtp_por_n) begin
         dirty_ff <= 1'b0;
      end else if (dirty_set) begin
         dirty_ff <= 1'b1;
      end else if (dirty_clr) begin
         dirty_ff <= 1'b0;
      end
   end

   // Asynchronous read, out-of-range entries read as zero
   assign rd_data = (rd_entry < 4'(NUM_ENTRY)) ? mem[rd_entry] : WORD_ZERO;
   assign dirty = dirty_ff;

endmodule

// [verilog/gcal_calib_top.sv]
// Calibration storage, boot copy, programming and output selection for a rate sensor
//
// Operation
// - At most seven reprogrammings after factory programming; then none.
// - Slot counter is thermometer coded, one more low bit per programming.
// - Quadratic scale and bias share one word, programmed together once.
// - New coefficients apply only if slot counter was correctly advanced.
// - Newly programmed coefficients take effect only after the next reset.
// - Programming overwrites stored words; old values are lost.
// - Selectable bypass presents raw rate at the output.
// - Temperature output is uncalibrated by default; relative value suffices.
// - Calibrated temperature is raw times stored gain plus stored offset.
// - Calibrated temperature scales at twenty counts per degree.
// - Gain is stored times two to the ninth, offset as is, unsigned.
// - Volatile gain and offset apply at once for a verification pass.
// - After reset, stored settings copy into system registers before valid output.
// - Calibrated-temperature select zero disables, one enables calibrated output.
// - Rate select zero gives calibrated rate, one gives raw rate.
module gcal_calib_top import gcal_pkg::*; (
   // Clock and resets
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic mtp_por_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Sensor data path
   input wire logic [23:0] raw_rate,
   input wire logic [15:0] raw_temp,
   output logic [23:0] rate_out,
   output logic [15:0] temp_out,
   output logic out_valid
);

   typedef struct packed {
      gcal_state_t st;
      logic [NUM_ENTRY-1:0][31:0] sys;
      logic [29:0] act_bcon;
      logic act_ok;
      logic [7:0] cnt;
      logic [3:0] ent;
      logic [3:0] tmr;
      logic [31:0] pdata;
      logic refused;
      logic [31:0] rdata;
      logic [23:0] rate;
      logic [15:0] temp;
      logic valid;
   } gcal_regs_t;

   gcal_regs_t r_ff;
   gcal_regs_t nxt_r;

   logic [5:0] idx;
   logic [4:0] dec;
   logic [4:0] pdec;
   logic acc;
   logic prog_req;
   logic prog_start;
   logic [31:0] prog_word;
   logic [31:0] stat_word;
   logic [3:0] mtp_rd_entry;
   logic [31:0] mtp_rd_data;
   logic mtp_dirty;
   logic mtp_wr;
   logic mtp_dirty_set;
   logic mtp_dirty_clr;
   logic [7:0] new_slot;
   logic [11:0] tgain;
   logic [11:0] tofs;
   logic [27:0] tprod;
   logic [15:0] tcal;
   logic rate_raw_sel;

   // Word index to storage entry, bit 4 flags a hit
   function automatic logic [4:0] map_idx(input logic [5:0] a);
      if (a == IDX_SLOT) begin
         map_idx = {1'b1, ENT_SLOT};
      end else if (a == IDX_TCAL) begin
         map_idx = {1'b1, ENT_TCAL};
      end else if (a == IDX_TSEL) begin
         map_idx = {1'b1, ENT_TSEL};
      end else if (a == IDX_SCQB) begin
         map_idx = {1'b1, ENT_SCQB};
      end else if (a == IDX_BLIN) begin
         map_idx = {1'b1, ENT_BLIN};
      end else if (a == IDX_BCON) begin
         map_idx = {1'b1, ENT_BCON};
      end else if (a == IDX_SLIN) begin
         map_idx = {1'b1, ENT_SLIN};
      end else if (a == IDX_SCON) begin
         map_idx = {1'b1, ENT_SCON};
      end else if (a == IDX_MIDTEMP) begin
         map_idx = {1'b1, ENT_MIDTEMP};
      end else begin
         map_idx = 5'h00;
      end
   endfunction

   // Nonvolatile words; the boot walk reads them, program commits write them
   gcal_mtp_store u_store (
      .ref_clk(ref_clk),
      .mtp_por_n(mtp_por_n),
      .wr_en(mtp_wr),
      .wr_entry(r_ff.ent),
      .wr_data(r_ff.pdata),
      .dirty_set(mtp_dirty_set),
      .dirty_clr(mtp_dirty_clr),
      .rd_entry(mtp_rd_entry),
      .rd_data(mtp_rd_data),
      .dirty(mtp_dirty)
   );

   // Bus decode; the bus stalls until the boot copy has finished
   assign idx = paddr[7:2];
   assign dec = map_idx(idx);
   assign pdec = map_idx(pwdata[5:0]);
   assign acc = psel && penable && (r_ff.st != ST_BOOT);
   assign pready = acc;
   assign pslverr = acc && !dec[4] && (idx != IDX_PROG) && (idx != IDX_STAT);
   assign prdata = r_ff.rdata;
   // A refused command leaves a sticky flag, since a host that only polls busy would miss it
   assign prog_req = acc && pwrite && (idx == IDX_PROG);
   assign prog_start = prog_req && (r_ff.st == ST_RUN) && pdec[4] && (r_ff.cnt != SLOT_FULL);
   assign prog_word = r_ff.sys[pdec[3:0]];
   assign mtp_rd_entry = r_ff.ent;

   // Status word seen by software
   always_comb begin
      stat_word = WORD_ZERO;
      stat_word[STAT_BOOTED] = (r_ff.st != ST_BOOT);
      stat_word[STAT_BUSY] = (r_ff.st == ST_PROG);
      stat_word[STAT_DIRTY] = mtp_dirty;
      stat_word[STAT_REFUSED] = r_ff.refused;
      stat_word[STAT_FULL] = (r_ff.cnt == SLOT_FULL);
   end

   // Temperature path runs from the volatile words so a trial calibration shows at once
   assign tgain = r_ff.sys[ENT_TCAL][TGAIN_LSB +: 12];
   assign tofs = r_ff.sys[ENT_TCAL][TOFS_LSB +: 12];
   assign tprod = 28'(raw_temp) * 28'(tgain);
   assign tcal = 16'(tprod[TGAIN_FRAC +: 16] + 16'(tofs));
   // Raw rate when bypassed, or when the last coefficient set was never committed
   assign rate_raw_sel = r_ff.sys[ENT_SLOT][BYPASS_BIT] || !r_ff.act_ok;
   assign new_slot = r_ff.pdata[SLOT_LSB +: 8];

   // Next-state logic
   always_comb begin
      nxt_r = r_ff;
      mtp_wr = 1'b0;
      mtp_dirty_set = 1'b0;
      mtp_dirty_clr = 1'b0;
      // Read data is captured while selected, so it stands through the access phase
      if (psel) begin
         if (dec[4]) begin
            nxt_r.rdata = r_ff.sys[dec[3:0]];
         end else if (idx == IDX_STAT) begin
            nxt_r.rdata = stat_word;
         end else begin
            nxt_r.rdata = WORD_ZERO;
         end
      end
      case (r_ff.st)
         ST_BOOT: begin
            // One stored word per cycle into the system registers
            nxt_r.sys[r_ff.ent] = mtp_rd_data;
            if (r_ff.ent == ENT_SLOT) begin
               nxt_r.cnt = mtp_rd_data[SLOT_LSB +: 8];
            end
            // Only the boot walk updates the coefficients in use
            if (r_ff.ent == ENT_BCON) begin
               nxt_r.act_bcon = mtp_rd_data[29:0];
            end
            if (r_ff.ent == ENT_MIDTEMP) begin
               nxt_r.st = ST_RUN;
               nxt_r.act_ok = !mtp_dirty;
               nxt_r.ent = ENT_SLOT;
            end else begin
               nxt_r.ent = r_ff.ent + 4'h1;
            end
         end
         ST_PROG: begin
            if (r_ff.tmr == TMR_LAST) begin
               mtp_wr = 1'b1;
               nxt_r.st = ST_RUN;
               if (r_ff.ent == ENT_SLOT) begin
                  nxt_r.cnt = new_slot;
                  // A single thermometer step validates the pending coefficient set
                  mtp_dirty_clr = (new_slot == {r_ff.cnt[6:0], 1'b1});
               end else if (r_ff.ent >= ENT_SCQB) begin
                  mtp_dirty_set = 1'b1;
               end
            end else begin
               nxt_r.tmr = r_ff.tmr + 4'h1;
            end
         end
         default: begin
         end
      endcase
      // Register writes; the program command latches the word at command time
      if (acc && pwrite) begin
         if (dec[4]) begin
            nxt_r.sys[dec[3:0]] = pwdata;
         end else if (idx == IDX_STAT && pwdata[STAT_REFUSED]) begin
            nxt_r.refused = 1'b0;
         end
      end
      if (prog_start) begin
         nxt_r.st = ST_PROG;
         nxt_r.ent = pdec[3:0];
         nxt_r.tmr = 4'h0;
         nxt_r.pdata = prog_word;
      end else if (prog_req) begin
         nxt_r.refused = 1'b1;
      end
      // Output selection, registered
      nxt_r.rate = rate_raw_sel ? raw_rate : 24'(raw_rate - r_ff.act_bcon[23:0]);
      nxt_r.temp = r_ff.sys[ENT_TSEL][TSEL_BIT] ? tcal : raw_temp;
      nxt_r.valid = (r_ff.st != ST_BOOT);
   end

   // State register; a reset restarts the boot copy
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         r_ff <= '{st: ST_BOOT, default: '0};
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign rate_out = r_ff.rate;
   assign temp_out = r_ff.temp;
   assign out_valid = r_ff.valid;

   // Checks
   localparam int PROG_WAIT = PROG_CYCLES;
   localparam int BOOT_LEN = NUM_ENTRY;
   logic [27:0] chk_tprod;
   logic [15:0] chk_tcal;
   assign chk_tprod = 28'(raw_temp) * 28'(r_ff.sys[ENT_TCAL][TGAIN_LSB +: 12]);
   assign chk_tcal = 16'(chk_tprod[27:9] + 19'(r_ff.sys[ENT_TCAL][TOFS_LSB +: 12]));

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   a_full_refuse: assert property (prog_req && r_ff.cnt == SLOT_FULL |=> r_ff.refused && r_ff.st != ST_PROG)
      else $error("program accepted with all slots used");
   a_prog_commit: assert property (prog_start |-> ##PROG_WAIT (mtp_wr && r_ff.pdata == $past(prog_word, PROG_WAIT)))
      else $error("program did not commit the latched word on time");
   a_prog_quiet: assert property ($rose(r_ff.st == ST_PROG) |-> !mtp_wr [*8])
      else $error("program committed too early");
   a_boot_walk: assert property (r_ff.st == ST_BOOT && r_ff.ent == ENT_SLOT |-> ##BOOT_LEN r_ff.st == ST_RUN)
      else $error("boot copy did not end after all words");
   a_boot_valid: assert property (r_ff.st == ST_BOOT |=> !out_valid)
      else $error("output valid during boot copy");
   a_gate_dirty: assert property (r_ff.st == ST_BOOT && r_ff.ent == ENT_MIDTEMP |=> r_ff.act_ok == !$past(mtp_dirty))
      else $error("coefficient use not gated by committed counter");
   a_coeff_held: assert property (r_ff.st != ST_BOOT |=> $stable(r_ff.act_bcon))
      else $error("active coefficients changed without reset");
   a_thermo_step: assert property (mtp_dirty_clr |=> r_ff.cnt[0] && r_ff.cnt == {$past(r_ff.cnt[6:0]), 1'b1})
      else $error("slot counter step is not thermometer");
   a_raw_rate: assert property (r_ff.sys[ENT_SLOT][BYPASS_BIT] |=> rate_out == $past(raw_rate))
      else $error("bypass did not give raw rate");
   a_temp_raw: assert property (!r_ff.sys[ENT_TSEL][TSEL_BIT] |=> temp_out == $past(raw_temp))
      else $error("uncalibrated temperature not raw");
   a_temp_cal: assert property (r_ff.sys[ENT_TSEL][TSEL_BIT] |=> temp_out == $past(chk_tcal))
      else $error("calibrated temperature wrong");

   // Boot copy: bus stalls, entries walk in order, output valid once done
   a_boot_stall: assert property (r_ff.st == ST_BOOT |-> !pready)
      else $error("bus answered during boot copy");
   a_run_valid: assert property (r_ff.st == ST_RUN |=> out_valid)
      else $error("output not valid after boot copy");
   a_boot_step: assert property (r_ff.st == ST_BOOT && r_ff.ent != ENT_MIDTEMP
      |=> r_ff.st == ST_BOOT && r_ff.ent == 4'($past(r_ff.ent) + 4'h1))
      else $error("boot copy skipped an entry");
   // Program commands, refusal and the slot counter
   a_full_no_prog: assert property (r_ff.cnt == SLOT_FULL && r_ff.st == ST_RUN |=> r_ff.st != ST_PROG)
      else $error("program started with all slots used");
   a_refuse_held: assert property (r_ff.refused && !(acc && pwrite && idx == IDX_STAT) |=> r_ff.refused)
      else $error("refused flag dropped without a clear");
   a_wr_only_prog: assert property (mtp_wr |-> r_ff.st == ST_PROG && r_ff.tmr == TMR_LAST)
      else $error("storage written outside a program");
   a_slot_commit: assert property (mtp_wr && r_ff.ent == ENT_SLOT |=> r_ff.cnt == $past(new_slot))
      else $error("slot counter not taken from committed word");
   a_dirty_mark: assert property (mtp_wr && r_ff.ent >= ENT_SCQB |=> mtp_dirty)
      else $error("coefficient program not marked pending");
   // Uncommitted coefficient set must leave the rate raw
   a_uncommitted_raw: assert property (!r_ff.act_ok |=> rate_out == $past(raw_rate))
      else $error("uncommitted coefficients applied to rate");

endmodule

// [bench/gcal_host_model.sv]
// Host controller model: APB master that issues register and program commands
module gcal_host_model (
   // Clock
   input wire logic ref_clk,
   // APB master side
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end

   // One transfer: setup, then access held until pready is seen high at a rising edge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      // Values read here are those that stood up to this edge
      while (pready !== 1'b1) begin
         @(posedge ref_clk);
      end
      q = prdata;
      err = pslverr;
      // Released only after the completing edge
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      xfer(1'b1, a, d, q, e);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
      xfer(1'b0, a, 32'h0000_0000, q, e);
   endtask
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the calibration storage block
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin err_count++; \
   $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module tb_top import gcal_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;

   logic ref_clk, rstn, mtp_por_n;
   logic psel, penable, pwrite, pready, pslverr, out_valid;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [23:0] raw_rate, rate_out;
   logic [15:0] raw_temp, temp_out;
   logic e;
   int err_count = 0;
   int num_checks = 0;
   int cycles = 0;

   gcal_calib_top gcal_calib_top_inst (.ref_clk(ref_clk), .rstn(rstn), .mtp_por_n(mtp_por_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .raw_rate(raw_rate),
      .raw_temp(raw_temp), .rate_out(rate_out), .temp_out(temp_out), .out_valid(out_valid));
   gcal_host_model gcal_host_model_inst (.ref_clk(ref_clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr));

   // 20 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // Run ceiling well above the expected few hundred cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         final_report();
      end
   end

   task automatic final_report();
      if (err_count == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      gcal_host_model_inst.rd(a, q, e);
      `CHK("read data", exp, q)
   endtask

   // Program one word, then wait a bounded time for busy to clear
   task automatic prog(input logic [5:0] idx);
      int n;
      gcal_host_model_inst.wr(8'hF0, {26'h0, idx});
      q = 32'hFFFF_FFFF;
      for (n = 0; n < 30 && q[STAT_BUSY] !== 1'b0; n++) gcal_host_model_inst.rd(8'hF4, q, e);
      `CHK("busy cleared", 1'b0, q[STAT_BUSY])
   endtask

   // Warm reset; APB reads stall until the boot copy is finished
   task automatic reboot();
      @(posedge ref_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (12) @(posedge ref_clk);
   endtask

   task automatic outchk(input logic [23:0] er, input logic [15:0] et);
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK("rate_out", er, rate_out)
      `CHK("temp_out", et, temp_out)
   endtask

   initial begin
      int k;
      rstn = 1'b0;
      mtp_por_n = 1'b0;
      raw_rate = 24'h001000;
      raw_temp = 16'h0064;
      repeat (10) @(posedge ref_clk);
      rstn <= 1'b1;
      mtp_por_n <= 1'b1;
      // Factory contents after boot
      rchk(8'h08, 32'h0000_0100);
      rchk(8'h10, 32'h0000_2000);
      rchk(8'h24, 32'h0000_0000);
      `CHK("out_valid", 1'b1, out_valid)
      outchk(24'h001000, 16'h0064);
      gcal_host_model_inst.rd(8'h00, q, e);
      `CHK("unmapped error", 1'b1, e)
      // Volatile gain 2.0 and offset 5 apply at once when selected
      gcal_host_model_inst.wr(8'h10, 32'h0005_1000);
      gcal_host_model_inst.wr(8'h24, 32'h0000_0004);
      outchk(24'h001000, 16'h00CD);
      // Coefficients in fixed order, quadratic pair as one word
      gcal_host_model_inst.wr(8'hB8, 32'h0001_0002);
      prog(IDX_SCQB);
      gcal_host_model_inst.wr(8'hC4, 32'h0000_0000);
      prog(IDX_SLIN);
      gcal_host_model_inst.wr(8'hC8, 32'h0000_0000);
      prog(IDX_SCON);
      gcal_host_model_inst.wr(8'hBC, 32'h0000_0000);
      prog(IDX_BLIN);
      gcal_host_model_inst.wr(8'hC0, 32'h0000_0005);
      prog(IDX_BCON);
      gcal_host_model_inst.wr(8'hCC, 32'h0000_0000);
      prog(IDX_MIDTEMP);
      outchk(24'h001000, 16'h00CD);
      // Counter not advanced: coefficients must not be used
      reboot();
      rchk(8'hC0, 32'h0000_0005);
      rchk(8'hB8, 32'h0001_0002);
      outchk(24'h001000, 16'h0064);
      // Advance counter one thermometer step and commit
      gcal_host_model_inst.wr(8'h08, 32'h0000_0300);
      prog(IDX_SLOT);
      outchk(24'h001000, 16'h0064);
      reboot();
      rchk(8'h08, 32'h0000_0300);
      outchk(24'h000FFB, 16'h0064);
      gcal_host_model_inst.wr(8'h08, 32'h0800_0300);
      outchk(24'h001000, 16'h0064);
      // Use up the remaining slots
      for (k = 3; k <= 8; k++) begin
         gcal_host_model_inst.wr(8'h08, ((32'h1 << k) - 32'h1) << 8);
         prog(IDX_SLOT);
      end
      gcal_host_model_inst.wr(8'hC0, 32'h0000_0009);
      prog(IDX_BCON);
      gcal_host_model_inst.rd(8'hF4, q, e);
      `CHK("refused and full", 2'b11, q[4:3])
      // Refused flag clears on a write of one; full stays
      gcal_host_model_inst.wr(8'hF4, 32'h0000_0008);
      rchk(8'hF4, 32'h0000_0011);
      reboot();
      rchk(8'hC0, 32'h0000_0005);
      rchk(8'h08, 32'h0000_FF00);
      outchk(24'h000FFB, 16'h0064);
      final_report();
   end
endmodule
